// ==== design/adcri_params.svh ====
// register indices, field positions, reset values and counts of the converter front end
`ifndef ADCRI_PARAMS_SVH
`define ADCRI_PARAMS_SVH
// ****************************************
// register indices (byte address = 4*index)
// ****************************************
`define ADCRI_IDX_CLK_SETUP 16'hFF13
`define ADCRI_IDX_CONV_CTRL 16'hFF80
`define ADCRI_IDX_RES_HIGH 16'hFF81
`define ADCRI_IDX_RES_LOW 16'hFF82
`define ADCRI_IDX_AIN_SEL 16'hFFE8
`define ADCRI_IDX_AOUT_SEL 16'hFFE9
`define ADCRI_IDX_IRQ_STAT 16'hFF2A
`define ADCRI_IDX_IRQ_MASK 16'hFF26
// ****************************************
// field positions
// ****************************************
`define ADCRI_DIV_MSB 2
`define ADCRI_DIV_LSB 0
`define ADCRI_GATE_BIT 3
`define ADCRI_START_BIT 7
`define ADCRI_DELEG_BIT 4
`define ADCRI_REFSW_BIT 3
`define ADCRI_CHAN_MSB 2
`define ADCRI_CHAN_LSB 0
`define ADCRI_AOUT0_BIT 6
`define ADCRI_AOUT1_BIT 7
`define ADCRI_DONE_BIT 7
`define ADCRI_RES_LOW_W 2
// ****************************************
// reset values and prescaler terminals
// ****************************************
`define ADCRI_RST_BYTE 8'h00
`define ADCRI_RST_DIV 3'h0
`define ADCRI_RST_CHAN 3'h0
`define ADCRI_RST_RES 10'h000
`define ADCRI_TERM_DIV16 4'hF
`define ADCRI_TERM_DIV8 4'h7
`define ADCRI_TERM_DIV4 4'h3
`define ADCRI_TERM_DIV2 4'h1
`define ADCRI_TERM_DIV1 4'h0
`endif

// ==== design/adcri_pkg.sv ====
// types shared by the converter front end
package adcri_pkg;
  // ****************************************
  // request toward the conversion core
  // ****************************************
  typedef struct packed {
    logic start;
    logic [2:0] chan;
    logic clk_tick;
  } adcri_conv_req_t;
  // ****************************************
  // answer from the conversion core
  // ****************************************
  typedef struct packed {
    logic done;
    logic [9:0] data;
  } adcri_conv_rsp_t;
  // ****************************************
  // routing of the shared port pins
  // ****************************************
  typedef struct packed {
    logic [7:0] ain_sel;
    logic [1:0] aout_sel;
    logic [7:0] port_out;
    logic [7:0] port_oe;
  } adcri_pins_t;
endpackage : adcri_pkg

// ==== design/adcri_top.sv ====
// converter control register front end behind a classic wishbone slave
`timescale 1ns/10ps
`default_nettype none
`include "adcri_params.svh"

module adcri_top (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [17:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output adcri_pkg::adcri_conv_req_t o_conv_req,
  input wire adcri_pkg::adcri_conv_rsp_t i_conv_rsp,
  input wire logic i_panel_ref_on,
  output logic o_ref_on,
  input wire logic [7:0] i_port_dir,
  input wire logic [7:0] i_port_data,
  output adcri_pkg::adcri_pins_t o_pins,
  output logic o_irq
);
  import adcri_pkg::*;

  // ****************************************
  // bus decode
  // ****************************************
  // access timing, seen from the master:
  // - first edge with cyc and stb high raises ack
  // - the edge that samples ack high lands a write
  // - ack falls on the edge after, even if stb stays
  // - a held stb would see ack every other cycle
  // misaligned or unlaned accesses are still acked,
  // so a stray master never hangs on this slave
  // only the low byte lane carries register data
  logic req; // live request
  logic ack_r; // registered acknowledge
  logic wr_fire; // write takes effect now
  logic [15:0] idx; // register index
  logic word_ok; // aligned word access
  logic lane0; // low byte lane enabled
  logic [7:0] wbyte; // written byte

  assign req = i_wb_cyc & i_wb_stb;
  assign idx = i_wb_adr[17:2];
  assign word_ok = (i_wb_adr[1:0] == 2'h0);
  assign lane0 = i_wb_sel[0];
  assign wbyte = i_wb_dat[7:0];
  // writes land on the edge where ack is seen
  assign wr_fire = req & i_wb_we & ack_r & word_ok & lane0;

  // per register write strobes
  logic wr_clk; // clock setup write
  logic wr_ctrl; // conversion control write
  logic wr_ain; // input select write
  logic wr_aout; // output select write
  logic wr_stat; // status write
  logic wr_mask; // mask write

  assign wr_clk = wr_fire & (idx == `ADCRI_IDX_CLK_SETUP);
  assign wr_ctrl = wr_fire & (idx == `ADCRI_IDX_CONV_CTRL);
  assign wr_ain = wr_fire & (idx == `ADCRI_IDX_AIN_SEL);
  assign wr_aout = wr_fire & (idx == `ADCRI_IDX_AOUT_SEL);
  assign wr_stat = wr_fire & (idx == `ADCRI_IDX_IRQ_STAT);
  assign wr_mask = wr_fire & (idx == `ADCRI_IDX_IRQ_MASK);

  // acknowledge one cycle after request, drop next
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  assign o_wb_ack = ack_r;

  // ****************************************
  // control registers
  // ****************************************
  logic [2:0] div_r; // prescaler ratio field
  logic gate_r; // converter clock gate
  logic deleg_r; // reference delegation
  logic refsw_r; // reference switch
  logic [2:0] chan_r; // channel select
  logic [7:0] ain_r; // analog input select
  logic aout0_r; // pin six to output
  logic aout1_r; // pin seven to output
  logic done_r; // complete flag, sticky
  logic mask_r; // complete flag mask
  logic [9:0] res_r; // conversion result
  logic start_r; // one cycle start pulse

  // clock setup register
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      div_r <= `ADCRI_RST_DIV;
      gate_r <= 1'b0;
    end else if (wr_clk) begin
      div_r <= wbyte[`ADCRI_DIV_MSB:`ADCRI_DIV_LSB];
      gate_r <= wbyte[`ADCRI_GATE_BIT];
    end
  end

  // conversion control register
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      deleg_r <= 1'b0;
      refsw_r <= 1'b0;
      chan_r <= `ADCRI_RST_CHAN;
    end else if (wr_ctrl) begin
      deleg_r <= wbyte[`ADCRI_DELEG_BIT];
      refsw_r <= wbyte[`ADCRI_REFSW_BIT];
      chan_r <= wbyte[`ADCRI_CHAN_MSB:`ADCRI_CHAN_LSB];
    end
  end

  // start trigger, a one is a pulse, a zero does nothing
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      start_r <= 1'b0;
    end else begin
      start_r <= wr_ctrl & wbyte[`ADCRI_START_BIT];
    end
  end

  // analog input select register
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ain_r <= `ADCRI_RST_BYTE;
    end else if (wr_ain) begin
      ain_r <= wbyte;
    end
  end

  // analog output select register, only two bits kept
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      aout0_r <= 1'b0;
      aout1_r <= 1'b0;
    end else if (wr_aout) begin
      aout0_r <= wbyte[`ADCRI_AOUT0_BIT];
      aout1_r <= wbyte[`ADCRI_AOUT1_BIT];
    end
  end

  // ****************************************
  // result and completion flag
  // ****************************************
  // the core answers with a one cycle done pulse;
  // its data is only trusted in that same cycle,
  // so the result is latched there and held until
  // the next completion. the two result bytes are
  // not locked together: software reads both
  // before it starts the next conversion
  // result captured when the core reports done
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      res_r <= `ADCRI_RST_RES;
    end else if (i_conv_rsp.done) begin
      res_r <= i_conv_rsp.data;
    end
  end

  // sticky flag, set beats a same cycle clear
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      done_r <= 1'b0;
    end else if (i_conv_rsp.done) begin
      done_r <= 1'b1;
    end else if (wr_stat & wbyte[`ADCRI_DONE_BIT]) begin
      done_r <= 1'b0; // write one to clear
    end
  end

  // mask gating the flag onto the interrupt
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      mask_r <= 1'b0;
    end else if (wr_mask) begin
      mask_r <= wbyte[`ADCRI_DONE_BIT];
    end
  end

  // level interrupt while an unmasked flag stands
  assign o_irq = done_r & mask_r;

  // ****************************************
  // prescaler
  // ****************************************
  // the divided clock is a tick, one core cycle wide,
  // once per ratio period; the core steps only on it.
  // terminal count is ratio minus one, so ratio one
  // ticks on every cycle. closing the gate clears the
  // counter, so the next opening starts a clean
  // period. a ratio change while running only costs
  // one short or long period, never a lost counter.
  // starting a conversion with the gate closed stalls
  // the core; that is left to software to avoid
  logic [3:0] term; // last count of a period
  logic [3:0] pcnt_r; // prescaler counter
  logic tick_r; // divided clock tick

  // ratio from the divider field, top bit wins
  always_comb begin
    term = `ADCRI_TERM_DIV1;
    if (div_r[2]) begin
      term = `ADCRI_TERM_DIV16;
    end else begin
      unique case (div_r[1:0])
        2'h3: term = `ADCRI_TERM_DIV8;
        2'h2: term = `ADCRI_TERM_DIV4;
        2'h1: term = `ADCRI_TERM_DIV2;
        2'h0: term = `ADCRI_TERM_DIV1;
      endcase
    end
  end

  // counter restarts if the ratio shrinks below it
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pcnt_r <= 4'h0;
    end else if (!gate_r) begin
      pcnt_r <= 4'h0;
    end else if (pcnt_r >= term) begin
      pcnt_r <= 4'h0;
    end else begin
      pcnt_r <= pcnt_r + 4'h1;
    end
  end

  // one tick per period, none while gated off
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= gate_r & (pcnt_r >= term);
    end
  end

  // ****************************************
  // conversion core request
  // ****************************************
  always_comb begin
    o_conv_req.start = start_r;
    o_conv_req.chan = chan_r;
    o_conv_req.clk_tick = tick_r;
  end

  // ****************************************
  // reference and pin routing
  // ****************************************
  // priority per pin: analog output, then analog
  // input, then plain port. only pins six and seven
  // have an output role. the reference pull uses the
  // effective reference, so a delegated panel drives
  // the external switch pin just like the register
  logic ref_on; // reference actually on
  logic [7:0] aout_pin; // pins taken by outputs
  logic [7:0] ain_eff; // pins routed as inputs
  logic [7:0] spare; // pins left to the port

  // panel controls the reference when delegated
  assign ref_on = deleg_r ? i_panel_ref_on : refsw_r;
  assign o_ref_on = ref_on;

  // output selects mark pins six and seven
  assign aout_pin = {aout1_r, aout0_r, 6'h00};

  // per pin routing
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      // output select overrides input select
      assign ain_eff[g] = ain_r[g] & ~aout_pin[g];
      // pin free when neither analog role holds
      assign spare[g] = ~ain_r[g] & ~aout_pin[g];
      // driven output holding one goes low with reference
      assign o_pins.port_out[g] = i_port_data[g] & ~ref_on;
      assign o_pins.port_oe[g] = spare[g] & i_port_dir[g];
    end
  endgenerate

  assign o_pins.ain_sel = ain_eff;
  assign o_pins.aout_sel = {aout1_r, aout0_r};

  // ****************************************
  // read back
  // ****************************************
  // the byte is built combinationally from the live
  // address and captured on the request edge, so it
  // stands through the ack cycle and is zero when
  // the bus is idle. write-only bits (gate, start)
  // never reach the read path. unmapped indices and
  // misaligned addresses fall through to zero
  logic [7:0] rbyte; // byte for the addressed register

  // unassigned bits and unmapped words read zero
  always_comb begin
    rbyte = 8'h00;
    if (word_ok) begin
      unique case (idx)
        `ADCRI_IDX_CLK_SETUP: begin
          // gate bit does not read back
          rbyte[`ADCRI_DIV_MSB:`ADCRI_DIV_LSB] = div_r;
        end
        `ADCRI_IDX_CONV_CTRL: begin
          // start bit always reads zero
          rbyte[`ADCRI_DELEG_BIT] = deleg_r;
          rbyte[`ADCRI_REFSW_BIT] = refsw_r;
          rbyte[`ADCRI_CHAN_MSB:`ADCRI_CHAN_LSB] = chan_r;
        end
        `ADCRI_IDX_RES_HIGH: begin
          rbyte = res_r[9:2];
        end
        `ADCRI_IDX_RES_LOW: begin
          rbyte[`ADCRI_RES_LOW_W-1:0] = res_r[1:0];
        end
        `ADCRI_IDX_AIN_SEL: begin
          rbyte = ain_r;
        end
        `ADCRI_IDX_AOUT_SEL: begin
          rbyte[`ADCRI_AOUT0_BIT] = aout0_r;
          rbyte[`ADCRI_AOUT1_BIT] = aout1_r;
        end
        `ADCRI_IDX_IRQ_STAT: begin
          rbyte[`ADCRI_DONE_BIT] = done_r;
        end
        `ADCRI_IDX_IRQ_MASK: begin
          rbyte[`ADCRI_DONE_BIT] = mask_r;
        end
        default: begin
          rbyte = 8'h00; // unmapped
        end
      endcase
    end
  end

  // read data captured with the request, held through ack
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (req & ~ack_r) begin
      o_wb_dat <= {24'h000000, rbyte};
    end else if (!req) begin
      o_wb_dat <= 32'h0000_0000;
    end
  end

endmodule // adcri_top
`default_nettype wire

// ==== test/adcri_top_sva.sv ====
// port assertions for the converter front end
`timescale 1ns/10ps
`default_nettype none
`include "adcri_params.svh"
module adcri_top_sva (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [17:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire adcri_pkg::adcri_conv_req_t o_conv_req,
  input wire logic o_ref_on,
  input wire logic [7:0] i_port_dir,
  input wire logic [7:0] i_port_data,
  input wire adcri_pkg::adcri_pins_t o_pins
);
  import adcri_pkg::*;
  logic [2:0] wr_chan; // channel field of the write data
  assign wr_chan = i_wb_dat[2:0];
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // write landing at one register
  sequence s_wr(logic [15:0] idx);
    o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr == {idx, 2'b00};
  endsequence
  // fresh request not yet answered
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  a_ack_answer: assert property (s_req |=> o_wb_ack)
    else $error("request not acked");
  a_read_upper: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_start_cause: assert property (s_wr(`ADCRI_IDX_CONV_CTRL) ##0 i_wb_dat[7] |=> o_conv_req.start)
    else $error("no start pulse");
  a_start_pulse: assert property (o_conv_req.start |=> !o_conv_req.start)
    else $error("start too long");
  a_chan_follow: assert property (s_wr(`ADCRI_IDX_CONV_CTRL) |=> o_conv_req.chan == $past(wr_chan))
    else $error("channel not taken");
  a_pin_oe: assert property (o_pins.port_oe == (i_port_dir & ~(o_pins.ain_sel | {o_pins.aout_sel, 6'h00})))
    else $error("pin enable wrong");
  a_out_override: assert property ((o_pins.ain_sel[7:6] & o_pins.aout_sel) == 2'b00)
    else $error("output select not winning");
  a_ref_pull: assert property (o_pins.port_out == (i_port_data & ~{8{o_ref_on}}))
    else $error("reference pin wrong");
  a_tick_stop: assert property (s_wr(`ADCRI_IDX_CLK_SETUP) ##0 !i_wb_dat[3] |=> ##1 !o_conv_req.clk_tick [*3])
    else $error("tick after gate off");
  a_tick_every: assert property (s_wr(`ADCRI_IDX_CLK_SETUP) ##0 i_wb_dat[3:0] == 4'h8 |=> ##3 o_conv_req.clk_tick [*3])
    else $error("undivided tick missing");
endmodule // adcri_top_sva
bind adcri_top adcri_top_sva u_adcri_top_sva (.i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .o_conv_req(o_conv_req), .o_ref_on(o_ref_on), .i_port_dir(i_port_dir),
  .i_port_data(i_port_data), .o_pins(o_pins));
`default_nettype wire

// ==== test/adcri_core_model.sv ====
// behavioural conversion core answering the front end
`timescale 1ns/10ps
`default_nettype none
module adcri_core_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire adcri_pkg::adcri_conv_req_t i_req,
  output var adcri_pkg::adcri_conv_rsp_t o_rsp
);
  import adcri_pkg::*;
  logic [2:0] chan_r; // channel latched at start
  logic [2:0] left_r; // ticks still to run
  logic busy_r; // conversion in flight
  // converts only on prescaler ticks, so a closed clock gate stalls it
  always_ff @(posedge i_clk) begin
    o_rsp.done <= 1'b0;
    if (i_reset) begin
      busy_r <= 1'b0;
      o_rsp.data <= 10'h3FF;
    end else if (i_req.start) begin
      busy_r <= 1'b1;
      left_r <= 3'h3;
      chan_r <= i_req.chan;
    end else if (busy_r && i_req.clk_tick) begin
      if (left_r == 3'h1) begin
        busy_r <= 1'b0;
        o_rsp.done <= 1'b1;
        o_rsp.data <= {chan_r, chan_r, chan_r, 1'b1};
      end else begin
        left_r <= left_r - 3'h1;
      end
    end else begin
      o_rsp.data <= ~o_rsp.data; // data churns when not valid
    end
  end
endmodule // adcri_core_model
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the converter front end
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import adcri_pkg::*;
  logic clk, rst, cyc, stb, we, ack, panel, ref_on, irq;
  logic [17:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, got;
  logic [7:0] pdir, pdata;
  logic [2:0] d, ch;
  logic [9:0] e;
  adcri_conv_req_t req;
  adcri_conv_rsp_t rsp;
  adcri_pins_t pins;
  int failures, n_tests, cycles, ticks, t0, n, nd;
  logic [15:0] regs [9] = '{16'hFF13, 16'hFF80, 16'hFF81, 16'hFF82, 16'hFFE8, 16'hFFE9,
    16'hFF2A, 16'hFF26, 16'hFF00};
  logic [2:0] divs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  adcri_top u_adcri_top (.i_core_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_conv_req(req), .i_conv_rsp(rsp), .i_panel_ref_on(panel),
    .o_ref_on(ref_on), .i_port_dir(pdir), .i_port_data(pdata), .o_pins(pins), .o_irq(irq));
  adcri_core_model u_adcri_core_model (.i_clk(clk), .i_reset(rst), .i_req(req), .o_rsp(rsp));
  always #10 clk = ~clk;
  always @(posedge clk) if (req.clk_tick === 1'b1) ticks++;
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask
  // one classic wishbone cycle, held until ack
  task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] v);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, v};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) failures++;
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [7:0] x);
    acc(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), 32'(x), got);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    {clk, cyc, stb, we, panel, adr, sel, wdat} = '0;
    {failures, n_tests, cycles, ticks} = '0;
    rst = 1'b1;
    pdir = 8'hF0;
    pdata = 8'hFF;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[i]) rdc(regs[i], 8'h00);
    $display("reset test done");
    acc(1'b1, 16'hFFE8, 8'hFF);
    rdc(16'hFFE8, 8'hFF);
    acc(1'b1, 16'hFFE9, 8'hFF);
    rdc(16'hFFE9, 8'hC0);
    chk("ain", 32'(8'h3F), 32'(pins.ain_sel));
    acc(1'b1, 16'hFFE8, 8'h00);
    acc(1'b1, 16'hFFE9, 8'h00);
    rdc(16'hFF00, 8'h00);
    $display("pin test done");
    acc(1'b1, 16'hFF80, 8'h1D);
    rdc(16'hFF80, 8'h1D);
    chk("ref", 32'h0, 32'(ref_on));
    panel <= 1'b1;
    @(negedge clk);
    chk("ref", 32'h1, 32'(ref_on));
    chk("chan", 32'h5, 32'(req.chan));
    acc(1'b1, 16'hFF80, 8'h08);
    panel <= 1'b0;
    @(negedge clk);
    chk("ref", 32'h1, 32'(ref_on));
    chk("pout", 32'h0, 32'(pins.port_out));
    acc(1'b1, 16'hFF80, 8'h00);
    @(negedge clk);
    chk("ref", 32'h0, 32'(ref_on));
    $display("reference test done");
    for (int i = 0; i < 6; i++) begin
      d = divs[i];
      ch = i[2:0];
      e = {ch, ch, ch, 1'b1};
      nd = d[2] ? 16 : (1 << d[1:0]);
      acc(1'b1, 16'hFF13, {5'h01, d});
      rdc(16'hFF13, {5'h00, d});
      acc(1'b1, 16'hFF26, {ch[0], 7'h00});
      acc(1'b1, 16'hFF80, {5'h10, ch});
      rdc(16'hFF80, {5'h00, ch});
      n = 0;
      while (rsp.done !== 1'b1 && n < 500) begin
        @(posedge clk);
        n++;
      end
      if (n >= 500) failures++;
      @(negedge clk);
      chk("irq", 32'(ch[0]), 32'(irq));
      rdc(16'hFF81, e[9:2]);
      rdc(16'hFF82, {6'h00, e[1:0]});
      rdc(16'hFF2A, 8'h80);
      acc(1'b1, 16'hFF2A, 8'h80);
      rdc(16'hFF2A, 8'h00);
      chk("irq", 32'h0, 32'(irq));
      t0 = ticks;
      repeat (64) @(negedge clk);
      chk("ticks", 32'(64 / nd), 32'(ticks - t0));
    end
    acc(1'b1, 16'hFF13, 8'h00);
    @(negedge clk);
    t0 = ticks;
    repeat (64) @(negedge clk);
    chk("ticks", 32'h0, 32'(ticks - t0));
    $display("conversion test done");
    stop_test();
  end
endmodule // testbench
`default_nettype wire
